// file: core/supply_cmd_core.sv
`timescale 1ns/1ps
module supply_cmd_core #(
   parameter int STATUS_W = supply_cmd_pkg::STATUS_W
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [STATUS_W-1:0] cond_in,
   input  wire logic                local_in,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     aux_a_n,
   output logic                     aux_b_n,
   output logic                     cal_mode,
   output logic                     fault_line,
   output logic                     irq
);

   localparam int EV_W = supply_cmd_pkg::EV_W;

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (STATUS_W < 1 || STATUS_W > supply_cmd_pkg::RESP_OP_LSB) begin : g_bad_width
      $error("STATUS_W must lie in 1..24");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [STATUS_W-1:0] live;
      logic [STATUS_W-1:0] acc;
      logic [STATUS_W-1:0] fault;
      logic [STATUS_W-1:0] fault_en;
      logic                fault_line;
      logic                aux_a;
      logic                aux_b;
      logic                aux_a_n;
      logic                aux_b_n;
      logic                cal;
      logic                pending;
      logic [STATUS_W-1:0] resp_val;
      logic [3:0]          resp_op;
      logic                resp_valid;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
   } core_t;

   core_t st;
   core_t next_st;

   logic [STATUS_W:0]   sync_q;
   logic [STATUS_W-1:0] cond_s;
   logic                local_s;
   logic [EV_W-1:0]     events;
   logic [EV_W-1:0]     irq_status;
   logic [EV_W-1:0]     irq_enable;
   logic                access;
   logic                wr;
   logic                cmd_fire;
   logic [3:0]          op;
   logic [1:0]          arg;
   logic                irq_clr_we;
   logic                irq_en_we;

   // {valid, on}: 1 and ON assert, 0 and OFF release, rest invalid
   function automatic logic [1:0] arg_dec(input logic [3:0] a);
      case (a)
         supply_cmd_pkg::ARG_ONE,
         supply_cmd_pkg::ARG_ON:   arg_dec = 2'h3;
         supply_cmd_pkg::ARG_ZERO,
         supply_cmd_pkg::ARG_OFF:  arg_dec = 2'h2;
         default:                  arg_dec = 2'h0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // pin inputs through two flops
   // ----------------------------------------------------------------
   cond_sync #(
      .W (STATUS_W + 1)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       ({local_in, cond_in}),
      .q       (sync_q)
   );

   assign cond_s  = sync_q[STATUS_W-1:0];
   assign local_s = sync_q[STATUS_W];

   // ----------------------------------------------------------------
   // apb strobes
   // ----------------------------------------------------------------
   // a write lands only on the edge where pready is sampled high
   assign access     = psel & penable & st.pready & ce;
   assign wr         = access & pwrite;
   assign cmd_fire   = wr & (paddr == supply_cmd_pkg::OFF_CMD);
   assign irq_clr_we = wr & (paddr == supply_cmd_pkg::OFF_IRQ_CLR);
   assign irq_en_we  = wr & (paddr == supply_cmd_pkg::OFF_IRQ_EN);
   assign op         = pwdata[supply_cmd_pkg::CMD_OP_LSB +: 4];
   assign arg        = arg_dec(pwdata[supply_cmd_pkg::CMD_ARG_LSB +: 4]);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      events  = '0;

      // live copy of the conditions every clock except on a status query
      next_st.live  = cond_s;
      // same bit layout, ored into the sticky copy
      next_st.acc   = st.acc | st.live;
      // unmasked condition raises its fault bit
      next_st.fault = st.fault | (st.live & st.fault_en);
      events[supply_cmd_pkg::EV_FAULT] = |(st.live & st.fault_en & ~st.fault);

      // release of the pending defaults once back in remote
      if (st.pending && !local_s) begin
         next_st.pending = 1'b0;
      end

      if (wr && paddr == supply_cmd_pkg::OFF_FAULT_EN) begin
         next_st.fault_en = pwdata[STATUS_W-1:0];
      end

      // command execution, one command per access edge
      if (cmd_fire) begin
         events[supply_cmd_pkg::EV_DONE] = 1'b1;
         next_st.resp_valid = 1'b0;
         next_st.resp_op    = op;
         case (op)
            supply_cmd_pkg::OP_ACC_STATUS_Q: begin
               // reply holds acc ored with live, one bit per condition
               next_st.resp_val   = st.acc | st.live;
               next_st.resp_valid = 1'b1;
               // query clears live; this cycle's sample lands in acc
               next_st.live = '0;
               next_st.acc  = cond_s;
            end
            supply_cmd_pkg::OP_AUX_A: begin
               if (arg[1]) begin
                  next_st.aux_a = arg[0];
               end else begin
                  events[supply_cmd_pkg::EV_ERR] = 1'b1;
               end
            end
            supply_cmd_pkg::OP_AUX_B: begin
               if (arg[1]) begin
                  next_st.aux_b = arg[0];
               end else begin
                  events[supply_cmd_pkg::EV_ERR] = 1'b1;
               end
            end
            supply_cmd_pkg::OP_AUX_A_Q: begin
               next_st.resp_val   = STATUS_W'(st.aux_a);
               next_st.resp_valid = 1'b1;
            end
            supply_cmd_pkg::OP_AUX_B_Q: begin
               next_st.resp_val   = STATUS_W'(st.aux_b);
               next_st.resp_valid = 1'b1;
            end
            supply_cmd_pkg::OP_CLEAR: begin
               // power-on settings, calibration untouched
               next_st.aux_a    = supply_cmd_pkg::AUX_RST;
               next_st.aux_b    = supply_cmd_pkg::AUX_RST;
               next_st.fault_en = {STATUS_W{supply_cmd_pkg::FAULT_EN_RST}};
               // faults cleared, a new one in this cycle still sets
               next_st.fault = st.live & st.fault_en;
               next_st.pending = local_s;
            end
            supply_cmd_pkg::OP_CAL: begin
               if (arg[1]) begin
                  next_st.cal = arg[0];
               end else begin
                  events[supply_cmd_pkg::EV_ERR] = 1'b1;
               end
            end
            supply_cmd_pkg::OP_CAL_Q: begin
               next_st.resp_val   = STATUS_W'(st.cal);
               next_st.resp_valid = 1'b1;
            end
            default: begin
               events[supply_cmd_pkg::EV_ERR] = 1'b1;
            end
         endcase
      end

      // pins follow the settings unless defaults wait for remote
      if (!next_st.pending) begin
         next_st.aux_a_n = ~next_st.aux_a;
         next_st.aux_b_n = ~next_st.aux_b;
      end
      next_st.fault_line = |next_st.fault;

      // apb answer is prepared in the setup cycle, so one wait-free access
      next_st.pready  = psel & ~penable;
      next_st.pslverr = 1'b0;
      next_st.prdata  = '0;
      if (psel && !penable) begin
         case (paddr)
            supply_cmd_pkg::OFF_CMD,
            supply_cmd_pkg::OFF_IRQ_CLR: next_st.prdata = '0;
            supply_cmd_pkg::OFF_RESP: begin
               next_st.prdata[STATUS_W-1:0]                     = st.resp_val;
               next_st.prdata[supply_cmd_pkg::RESP_OP_LSB +: 4] = st.resp_op;
               next_st.prdata[supply_cmd_pkg::RESP_VALID]       = st.resp_valid;
            end
            supply_cmd_pkg::OFF_LIVE:     next_st.prdata[STATUS_W-1:0] = st.live;
            supply_cmd_pkg::OFF_FAULT:    next_st.prdata[STATUS_W-1:0] = st.fault;
            supply_cmd_pkg::OFF_FAULT_EN: next_st.prdata[STATUS_W-1:0] = st.fault_en;
            supply_cmd_pkg::OFF_IRQ_STAT: next_st.prdata[EV_W-1:0]     = irq_status;
            supply_cmd_pkg::OFF_IRQ_EN:   next_st.prdata[EV_W-1:0]     = irq_enable;
            supply_cmd_pkg::OFF_SETTINGS: begin
               next_st.prdata[supply_cmd_pkg::SET_AUX_A]   = st.aux_a;
               next_st.prdata[supply_cmd_pkg::SET_AUX_B]   = st.aux_b;
               next_st.prdata[supply_cmd_pkg::SET_CAL]     = st.cal;
               next_st.prdata[supply_cmd_pkg::SET_PENDING] = st.pending;
               next_st.prdata[supply_cmd_pkg::SET_LOCAL]   = local_s;
            end
            default: next_st.pslverr = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // pins reset deasserted (high), calibration off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st         <= '0;
         st.aux_a   <= supply_cmd_pkg::AUX_RST;
         st.aux_b   <= supply_cmd_pkg::AUX_RST;
         st.aux_a_n <= 1'b1;
         st.aux_b_n <= 1'b1;
         st.cal     <= supply_cmd_pkg::CAL_RST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, clear and enable
   // ----------------------------------------------------------------
   irq_regs #(
      .N (EV_W)
   ) u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .events  (events),
      .clr_we  (irq_clr_we),
      .en_we   (irq_en_we),
      .wdata   (pwdata[EV_W-1:0]),
      .status  (irq_status),
      .enable  (irq_enable),
      .irq     (irq)
   );

   assign prdata     = st.prdata;
   assign pready     = st.pready;
   assign pslverr    = st.pslverr;
   assign aux_a_n    = st.aux_a_n;
   assign aux_b_n    = st.aux_b_n;
   assign cal_mode   = st.cal;
   assign fault_line = st.fault_line;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic q_acc;
   logic q_clr;
   assign q_acc = cmd_fire && op == supply_cmd_pkg::OP_ACC_STATUS_Q;
   assign q_clr = cmd_fire && op == supply_cmd_pkg::OP_CLEAR;

   chk_acc_sticky: assert property (
      (ce && !q_acc) |=> ((st.acc & $past(st.live)) == $past(st.live)))
      else $error("accumulated bit missed a live bit");
   chk_acc_reply: assert property (
      q_acc |=> (st.resp_val == $past(st.acc | st.live)) && st.resp_valid)
      else $error("accumulated reply wrong");
   chk_live_clear: assert property (
      q_acc |=> (st.live == '0) ##1 (st.live == $past(cond_s)))
      else $error("live status not cleared by query");
   chk_aux_a_pin: assert property (
      !st.pending |-> (aux_a_n == !st.aux_a))
      else $error("aux a pin disagrees with setting");
   chk_aux_b_pin: assert property (
      !st.pending |-> (aux_b_n == !st.aux_b))
      else $error("aux b pin disagrees with setting");
   chk_aux_query: assert property (
      (cmd_fire && op == supply_cmd_pkg::OP_AUX_A_Q)
      |=> st.resp_val == STATUS_W'($past(st.aux_a)) && st.resp_op == supply_cmd_pkg::OP_AUX_A_Q)
      else $error("aux a query reply wrong");
   chk_clear_dflt: assert property (
      q_clr |=> !st.aux_a && !st.aux_b && st.fault_en == '0)
      else $error("clear left a setting");
   chk_clear_local: assert property (
      (q_clr && local_s) |=> st.pending && $stable(aux_a_n) && $stable(aux_b_n))
      else $error("defaults applied while local");
   chk_clear_fault: assert property (
      q_clr |=> (st.fault & ~$past(st.live & st.fault_en)) == '0)
      else $error("fault survived clear");
   chk_clear_cal: assert property (
      q_clr |=> $stable(st.cal))
      else $error("clear changed calibration mode");
   chk_cal_switch: assert property (
      (cmd_fire && op == supply_cmd_pkg::OP_CAL && arg[1]) |=> st.cal == $past(arg[0]))
      else $error("calibration mode did not follow");
   chk_cal_query: assert property (
      (cmd_fire && op == supply_cmd_pkg::OP_CAL_Q) |=> st.resp_val == STATUS_W'($past(st.cal)))
      else $error("calibration query wrong");
   chk_fault_set: assert property (
      (ce && (st.live & st.fault_en) != '0) |=> ((st.fault & $past(st.live & st.fault_en)) != '0))
      else $error("unmasked condition set no fault");
   chk_live_load: assert property (
      (ce && !q_acc) |=> st.live == $past(cond_s))
      else $error("live status not refreshed");
   chk_bad_arg: assert property (
      (cmd_fire && op == supply_cmd_pkg::OP_AUX_B && !arg[1])
      |=> $stable(st.aux_b) && irq_status[supply_cmd_pkg::EV_ERR])
      else $error("bad argument not refused");

   cov_acc_query: cover property (q_acc ##1 st.resp_val != '0);
   cov_clear_local: cover property (q_clr && local_s ##[1:50] !st.pending);
   cov_bad_arg: cover property (cmd_fire && !arg[1] && op == supply_cmd_pkg::OP_CAL);
   cov_irq: cover property (irq);

endmodule

// file: shared/supply_cmd_pkg.sv
package supply_cmd_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int STATUS_W = 8;
   localparam int OP_W     = 4;
   localparam int ARG_W    = 4;
   localparam int EV_W     = 3;

   // ----------------------------------------------------------------
   // apb byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CMD      = 8'h00;
   localparam logic [7:0] OFF_RESP     = 8'h04;
   localparam logic [7:0] OFF_LIVE     = 8'h08;
   localparam logic [7:0] OFF_FAULT    = 8'h0c;
   localparam logic [7:0] OFF_FAULT_EN = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h18;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h1c;
   localparam logic [7:0] OFF_SETTINGS = 8'h20;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_ARG_LSB = 8;
   localparam int RESP_OP_LSB = 24;
   localparam int RESP_VALID  = 31;
   localparam int SET_AUX_A   = 0;
   localparam int SET_AUX_B   = 1;
   localparam int SET_CAL     = 2;
   localparam int SET_PENDING = 3;
   localparam int SET_LOCAL   = 4;
   localparam int EV_DONE     = 0;
   localparam int EV_ERR      = 1;
   localparam int EV_FAULT    = 2;

   // ----------------------------------------------------------------
   // command and argument codes
   // ----------------------------------------------------------------
   localparam logic [3:0] OP_ACC_STATUS_Q = 4'h1;
   localparam logic [3:0] OP_AUX_A        = 4'h2;
   localparam logic [3:0] OP_AUX_A_Q      = 4'h3;
   localparam logic [3:0] OP_AUX_B        = 4'h4;
   localparam logic [3:0] OP_AUX_B_Q      = 4'h5;
   localparam logic [3:0] OP_CLEAR        = 4'h6;
   localparam logic [3:0] OP_CAL          = 4'h7;
   localparam logic [3:0] OP_CAL_Q        = 4'h8;
   localparam logic [3:0] ARG_ZERO        = 4'h0;
   localparam logic [3:0] ARG_ONE         = 4'h1;
   localparam logic [3:0] ARG_ON          = 4'h2;
   localparam logic [3:0] ARG_OFF         = 4'h3;

   // ----------------------------------------------------------------
   // values after reset, and after clear except CAL_RST
   // ----------------------------------------------------------------
   localparam logic AUX_RST      = 1'b0;
   localparam logic CAL_RST      = 1'b0;
   localparam logic FAULT_EN_RST = 1'b0;

endpackage

// file: core/cond_sync.sv
`timescale 1ns/1ps
module cond_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t st;
   sync_t next_st;

   // first stage feeds only the second one
   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign q = st.s2;

endmodule

// file: core/irq_regs.sv
`timescale 1ns/1ps
module irq_regs #(
   parameter int N = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [N-1:0] events,
   input  wire logic         clr_we,
   input  wire logic         en_we,
   input  wire logic [N-1:0] wdata,
   output logic      [N-1:0] status,
   output logic      [N-1:0] enable,
   output logic              irq
);

   typedef struct packed {
      logic [N-1:0] status;
      logic [N-1:0] enable;
      logic         irq;
   } irq_state_t;

   irq_state_t st;
   irq_state_t next_st;

   // set beats clear so an event in the clear cycle survives
   always_comb begin
      next_st        = st;
      next_st.status = (st.status & ~(clr_we ? wdata : '0)) | events;
      if (en_we) begin
         next_st.enable = wdata;
      end
      next_st.irq = |(next_st.status & next_st.enable);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign status = st.status;
   assign enable = st.enable;
   assign irq    = st.irq;

   chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && (events != '0)) |=> ((status & $past(events)) == $past(events)))
      else $error("irq event lost");
   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (|(status & enable)))
      else $error("irq level mismatch");

endmodule

// file: sim/supply_plant_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// supply side: condition pins and local/remote switch
// ----------------------------------------------------------------
module supply_plant_model (
   input  wire logic       pclk,
   input  wire logic [7:0] cond_req,
   input  wire logic       local_req,
   output logic      [7:0] cond_in,
   output logic            local_in
);
   // one-cycle requests stay one cycle wide, the narrowest glitch the core must catch
   always_ff @(posedge pclk) begin
      cond_in  <= cond_req;
      local_in <= local_req;
   end
endmodule

// file: sim/supply_status_aux_cal_cmds_tb.sv
`timescale 1ns/1ps
module supply_status_aux_cal_cmds_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0]  cond_req = 8'h00;
   logic        local_req = 1'b0;
   logic [7:0]  cond_in;
   logic        local_in;
   logic [31:0] prdata;
   logic        pready, pslverr, aux_a_n, aux_b_n, cal_mode, fault_line, irq;
   logic [31:0] rd;
   logic        err;
   int          fail_count = 0;
   int          samples_checked = 0;

   // ----------------------------------------------------------------
   // clock, plant and core
   // ----------------------------------------------------------------
   always #10 pclk = ~pclk;
   supply_plant_model plant (.pclk(pclk), .cond_req(cond_req), .local_req(local_req),
      .cond_in(cond_in), .local_in(local_in));
   supply_cmd_core dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cond_in(cond_in), .local_in(local_in),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_a_n(aux_a_n), .aux_b_n(aux_b_n),
      .cal_mode(cal_mode), .fault_line(fault_line), .irq(irq));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; an idle cycle follows so psel is never lowered and raised in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 16) begin
         fail_count++;
         $display("mismatch at %0t: no pready", $time);
         tally_and_finish();
      end
   endtask

   task automatic cmd(input logic [3:0] op, input logic [3:0] arg);
      apb(1'b1, supply_cmd_pkg::OFF_CMD, {20'h0, arg, 4'h0, op});
   endtask

   // query then read the reply register
   task automatic ask(input logic [3:0] op, input logic [31:0] exp);
      cmd(op, 4'h0);
      apb(1'b0, supply_cmd_pkg::OFF_RESP, 32'h0);
      chk(rd, exp);
   endtask

   // single-cycle condition glitch, then enough cycles for the sync stages
   task automatic glitch(input logic [7:0] v);
      cond_req <= v;
      @(posedge pclk);
      cond_req <= 8'h00;
      repeat (5) @(posedge pclk);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({aux_b_n, aux_a_n, cal_mode}, 32'h6);
      apb(1'b0, supply_cmd_pkg::OFF_SETTINGS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      // aux lines, every argument code, and their queries
      cmd(supply_cmd_pkg::OP_AUX_A, supply_cmd_pkg::ARG_ON);
      chk(aux_a_n, 32'h0);
      ask(supply_cmd_pkg::OP_AUX_A_Q, 32'h83000001);
      cmd(supply_cmd_pkg::OP_AUX_A, supply_cmd_pkg::ARG_OFF);
      chk(aux_a_n, 32'h1);
      ask(supply_cmd_pkg::OP_AUX_A_Q, 32'h83000000);
      cmd(supply_cmd_pkg::OP_AUX_B, supply_cmd_pkg::ARG_ONE);
      chk(aux_b_n, 32'h0);
      ask(supply_cmd_pkg::OP_AUX_B_Q, 32'h85000001);
      cmd(supply_cmd_pkg::OP_AUX_B, supply_cmd_pkg::ARG_ZERO);
      chk(aux_b_n, 32'h1);
      cmd(supply_cmd_pkg::OP_AUX_B, supply_cmd_pkg::ARG_ON);
      // bad argument: error interrupt, setting kept
      apb(1'b1, supply_cmd_pkg::OFF_IRQ_EN, 32'h2);
      cmd(supply_cmd_pkg::OP_AUX_B, 4'h9);
      apb(1'b0, supply_cmd_pkg::OFF_IRQ_STAT, 32'h0);
      chk({rd[1], irq, aux_b_n}, 32'h6);
      apb(1'b1, supply_cmd_pkg::OFF_IRQ_CLR, 32'h2);
      apb(1'b0, supply_cmd_pkg::OFF_IRQ_STAT, 32'h0);
      chk({rd[1], irq}, 32'h0);
      // unknown opcode and bad calibration argument raise the error, mode kept off
      cmd(4'hf, 4'h0);
      cmd(supply_cmd_pkg::OP_CAL, 4'h7);
      apb(1'b0, supply_cmd_pkg::OFF_IRQ_STAT, 32'h0);
      chk({rd[1], irq, cal_mode}, 32'h6);
      apb(1'b1, supply_cmd_pkg::OFF_IRQ_CLR, 32'h2);
      // calibration mode survives the clear, aux returns to off
      cmd(supply_cmd_pkg::OP_CAL, supply_cmd_pkg::ARG_ONE);
      ask(supply_cmd_pkg::OP_CAL_Q, 32'h88000001);
      cmd(supply_cmd_pkg::OP_CLEAR, 4'h0);
      chk({aux_b_n, cal_mode}, 32'h3);
      ask(supply_cmd_pkg::OP_CAL_Q, 32'h88000001);
      cmd(supply_cmd_pkg::OP_CAL, supply_cmd_pkg::ARG_OFF);
      ask(supply_cmd_pkg::OP_CAL_Q, 32'h88000000);
      // accumulated status catches a gone glitch, then starts empty
      glitch(8'h05);
      ask(supply_cmd_pkg::OP_ACC_STATUS_Q, 32'h81000005);
      ask(supply_cmd_pkg::OP_ACC_STATUS_Q, 32'h81000000);
      // fault bit only for the unmasked condition, emptied by clear
      apb(1'b1, supply_cmd_pkg::OFF_FAULT_EN, 32'h2);
      glitch(8'h03);
      apb(1'b0, supply_cmd_pkg::OFF_FAULT, 32'h0);
      chk({fault_line, rd[30:0]}, 32'h80000002);
      cmd(supply_cmd_pkg::OP_CLEAR, 4'h0);
      apb(1'b0, supply_cmd_pkg::OFF_FAULT, 32'h0);
      chk({fault_line, rd[30:0]}, 32'h0);
      // clear under local control waits for remote
      local_req <= 1'b1;
      repeat (5) @(posedge pclk);
      cmd(supply_cmd_pkg::OP_AUX_A, supply_cmd_pkg::ARG_ONE);
      cmd(supply_cmd_pkg::OP_CLEAR, 4'h0);
      apb(1'b0, supply_cmd_pkg::OFF_SETTINGS, 32'h0);
      chk({aux_a_n, rd[30:0]}, 32'h18);
      local_req <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(aux_a_n, 32'h1);
      tally_and_finish();
   end
endmodule
